/* port_a_pkg.sv */
package port_a_pkg;

    // ------------------------------------------------------------
    // register map: word index, byte address is four times index
    // ------------------------------------------------------------
    localparam int ADR_W = 10;
    localparam logic [7:0] IDX_PINS = 8'h05;
    localparam logic [7:0] IDX_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_ANALOG_CFG = 8'h9F;

    // ------------------------------------------------------------
    // widths, fields and reset values
    // ------------------------------------------------------------
    localparam int PORT_W = 6;
    localparam int TIMER_BIT = 4;
    localparam logic [5:0] LATCH_RST = 6'h00;
    localparam logic [5:0] DIRECTION_RST = 6'h3F;
    localparam logic [7:0] ANALOG_CFG_RST = 8'h00;
    localparam int JUSTIFY_POS = 7;
    localparam logic [7:0] ANALOG_CFG_MASK = 8'h8F;

    // ------------------------------------------------------------
    // analog configuration codes and pin masks
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_ALL_ANALOG = 4'h0;
    localparam logic [3:0] CFG_ANALOG_REF = 4'h1;
    localparam logic [3:0] CFG_DIGITAL_A = 4'h6;
    localparam logic [3:0] CFG_DIGITAL_B = 4'h7;
    localparam logic [5:0] MASK_ALL_ANALOG = 6'h2F;
    localparam logic [5:0] MASK_REF_ANALOG = 6'h27;
    localparam logic [5:0] MASK_NONE = 6'h00;
    localparam logic [5:0] MASK_PARTIAL = 6'h0B;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_type;

endpackage

/* sync_bits.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
    parameter int WIDTH = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* pin_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic latch_i,
    input wire logic input_mode_i,
    input wire logic periph_en_i,
    input wire logic periph_out_i,
    input wire logic periph_oe_i,
    output logic pin_out_o,
    output logic pin_oe_o
);

    logic out_d;
    logic oe_d;

    // select port or peripheral, then shape the driver type
    always_comb
    begin
        out_d = latch_i;
        oe_d = !input_mode_i;
        if (periph_en_i)
        begin
            out_d = periph_out_i;
            oe_d = periph_oe_i;
        end
        if (OPEN_DRAIN)
        begin
            oe_d = oe_d && !out_d;
            out_d = 1'b0;
        end
    end

    // registered pin drive, released on reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_out_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else
        begin
            pin_out_o <= out_d;
            pin_oe_o <= oe_d;
        end
    end

endmodule
`default_nettype wire

/* six_bit_port_a.sv */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module six_bit_port_a #(
    parameter int PORT_W = port_a_pkg::PORT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [port_a_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [PORT_W-1:0] pin_in_i,
    output logic [PORT_W-1:0] pin_out_o,
    output logic [PORT_W-1:0] pin_oe_o,
    input wire logic [PORT_W-1:0] periph_en_i,
    input wire logic [PORT_W-1:0] periph_out_i,
    input wire logic [PORT_W-1:0] periph_oe_i,
    output logic counter_clock_o,
    output logic [PORT_W-1:0] analog_en_o,
    output logic ref_select_o,
    output logic result_justify_select_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [PORT_W-1:0] pins_sync;
    logic [PORT_W-1:0] latch_q;
    logic [PORT_W-1:0] latch_d;
    logic [PORT_W-1:0] direction_q;
    logic [7:0] analog_cfg_q;
    logic [PORT_W-1:0] analog_mask;
    logic [PORT_W-1:0] pins_read;
    port_a_pkg::bus_state_type bus_q;
    logic req;
    logic take;
    logic [7:0] index;
    logic hit_pins;
    logic hit_dir;
    logic hit_cfg;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // pin input synchronisation
    // ------------------------------------------------------------

    // pins come from outside the clock domain
    sync_bits #(
        .WIDTH(PORT_W)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pin_in_i),
        .sync_o(pins_sync)
    );

    // ------------------------------------------------------------
    // analog configuration decode
    // ------------------------------------------------------------

    // map configuration code to the set of analog pins
    always_comb
    begin
        unique case (analog_cfg_q[3:0])
            port_a_pkg::CFG_ALL_ANALOG: analog_mask = port_a_pkg::MASK_ALL_ANALOG;
            port_a_pkg::CFG_ANALOG_REF: analog_mask = port_a_pkg::MASK_REF_ANALOG;
            port_a_pkg::CFG_DIGITAL_A: analog_mask = port_a_pkg::MASK_NONE;
            port_a_pkg::CFG_DIGITAL_B: analog_mask = port_a_pkg::MASK_NONE;
            default: analog_mask = port_a_pkg::MASK_PARTIAL;
        endcase
    end

    // digital read path is blocked on analog pins
    assign pins_read = pins_sync & ~analog_mask;

    // ------------------------------------------------------------
    // wishbone classic slave
    // ------------------------------------------------------------

    // request decode; word index from byte address
    assign req = cyc_i && stb_i;
    assign take = req && (bus_q == port_a_pkg::BUS_IDLE);
    assign index = adr_i[port_a_pkg::ADR_W-1:2];
    assign hit_pins = (index == port_a_pkg::IDX_PINS);
    assign hit_dir = (index == port_a_pkg::IDX_DIRECTION);
    assign hit_cfg = (index == port_a_pkg::IDX_ANALOG_CFG);

    // one ack per request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_q <= port_a_pkg::BUS_IDLE;
        end
        else
        begin
            unique case (bus_q)
                port_a_pkg::BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_q <= port_a_pkg::BUS_ACK;
                    end
                end
                port_a_pkg::BUS_ACK: bus_q <= port_a_pkg::BUS_IDLE;
                default: bus_q <= port_a_pkg::BUS_IDLE;
            endcase
        end
    end

    // ack output straight from a flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= take;
        end
    end

    // read mux; unmapped and unimplemented bits read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (hit_pins)
        begin
            rdata_d[PORT_W-1:0] = pins_read;
        end
        else if (hit_dir)
        begin
            rdata_d[PORT_W-1:0] = direction_q;
        end
        else if (hit_cfg)
        begin
            rdata_d[7:0] = analog_cfg_q & port_a_pkg::ANALOG_CFG_MASK;
        end
    end

    // read data captured with the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (take && !we_i)
        begin
            dat_o <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------

    // write merges byte lane 0 over the sampled pin levels
    always_comb
    begin
        latch_d = pins_sync;
        if (sel_i[0])
        begin
            latch_d = dat_i[PORT_W-1:0];
        end
    end

    // output latch; bit 4 survives all but power-on reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            latch_q[3:0] <= port_a_pkg::LATCH_RST[3:0];
            latch_q[5] <= port_a_pkg::LATCH_RST[5];
            if (por_i)
            begin
                latch_q[4] <= port_a_pkg::LATCH_RST[4];
            end
        end
        else if (take && we_i && hit_pins)
        begin
            latch_q <= latch_d;
        end
    end

    // direction register, all inputs after any reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            direction_q <= port_a_pkg::DIRECTION_RST;
        end
        else if (take && we_i && hit_dir && sel_i[0])
        begin
            direction_q <= dat_i[PORT_W-1:0];
        end
    end

    // analog configuration, all analog but bit 4 after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            analog_cfg_q <= port_a_pkg::ANALOG_CFG_RST;
        end
        else if (take && we_i && hit_cfg && sel_i[0])
        begin
            analog_cfg_q <= dat_i[7:0] & port_a_pkg::ANALOG_CFG_MASK;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------

    // one driver per bit; bit 4 is open drain
    generate
        for (genvar i = 0; i < PORT_W; i++)
        begin : g_pin
            pin_driver #(
                .OPEN_DRAIN(i == port_a_pkg::TIMER_BIT)
            ) u_drv (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .latch_i(latch_q[i]),
                .input_mode_i(direction_q[i]),
                .periph_en_i(periph_en_i[i]),
                .periph_out_i(periph_out_i[i]),
                .periph_oe_i(periph_oe_i[i]),
                .pin_out_o(pin_out_o[i]),
                .pin_oe_o(pin_oe_o[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // side outputs to timer and converter
    // ------------------------------------------------------------

    // timer clock, analog enables and reference select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            counter_clock_o <= 1'b0;
            analog_en_o <= port_a_pkg::MASK_ALL_ANALOG;
            ref_select_o <= 1'b0;
            result_justify_select_o <= 1'b0;
        end
        else
        begin
            counter_clock_o <= pins_sync[port_a_pkg::TIMER_BIT];
            analog_en_o <= analog_mask;
            ref_select_o <= (analog_cfg_q[3:0] == port_a_pkg::CFG_ANALOG_REF);
            result_justify_select_o <= analog_cfg_q[port_a_pkg::JUSTIFY_POS];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence write_pins_s;
        take && we_i && hit_pins && sel_i[0];
    endsequence

    sequence read_pins_s;
        take && !we_i && hit_pins;
    endsequence

    // read answered this cycle; dat_o was loaded at the taking edge
    sequence read_answer_s;
        ack_o && !$past(we_i);
    endsequence

    chk_input_hiz: assert property (
        (direction_q != 6'h00) && (periph_en_i == 6'h00) ##1 (periph_en_i == 6'h00)
        |-> ((pin_oe_o & $past(direction_q)) == 6'h00))
        else $error("input pin still driven");

    chk_output_latch: assert property (
        !direction_q[0] && !periph_en_i[0] |=> pin_oe_o[0] && (pin_out_o[0] == $past(latch_q[0])))
        else $error("output pin not driven from latch");

    chk_open_drain: assert property (
        !pin_out_o[4] && (pin_oe_o[4] -> $past(!latch_q[4] || periph_en_i[4])))
        else $error("open-drain pin driven high");

    chk_read_pins: assert property (
        read_pins_s |=> ack_o && (dat_o == {26'h000_0000, $past(pins_read)}))
        else $error("port read does not return pin levels");

    chk_write_latch: assert property (
        write_pins_s |=> ack_o && (latch_q == $past(dat_i[5:0])))
        else $error("port write did not reach the latch");

    chk_timer_clock: assert property (
        !rst_i |-> ##3 (counter_clock_o == $past(pin_in_i[4], 3)))
        else $error("timer clock does not follow pin");

    chk_analog_zero: assert property (
        read_pins_s ##1 (analog_cfg_q[3:0] == port_a_pkg::CFG_ALL_ANALOG)
        |-> (dat_o[5:0] & port_a_pkg::MASK_ALL_ANALOG) == 6'h00)
        else $error("analog pin read as nonzero");

    chk_direction_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> (direction_q == port_a_pkg::DIRECTION_RST))
        else $error("direction not all inputs after reset");

    chk_latch_reset: assert property (@(posedge clk_i)
        $past(rst_i) && !$past(por_i) |-> (latch_q[4] == $past(latch_q[4]))
        && (latch_q[3:0] == 4'h0) && !latch_q[5])
        else $error("latch reset value wrong");

    chk_unimpl_zero: assert property (
        read_answer_s |-> (dat_o[31:8] == 24'h00_0000)
        && ($past(hit_cfg) ? (dat_o[6:4] == 3'h0) : (dat_o[7:6] == 2'h0)))
        else $error("unimplemented bits read nonzero");

    chk_unmapped_zero: assert property (
        ack_o && !$past(we_i) && !$past(hit_pins || hit_dir || hit_cfg) |-> (dat_o == 32'h0000_0000))
        else $error("unmapped read returned data");

    chk_ref_not_input: assert property (
        ref_select_o |-> !analog_en_o[3] && analog_en_o[0])
        else $error("reference pin also routed as analog input");

    chk_periph_take: assert property (
        periph_en_i[0] && periph_oe_i[0] |=> pin_oe_o[0] && (pin_out_o[0] == $past(periph_out_i[0])))
        else $error("peripheral did not take the pin");

    chk_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

/* pin_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
    input wire logic [5:0] pin_out_i,
    input wire logic [5:0] pin_oe_i,
    input wire logic [5:0] ext_en_i,
    input wire logic [5:0] ext_val_i,
    output logic [5:0] level_o
);
    // --------------------------------------------
    // board wiring: chip driver, external source, pull-up
    // --------------------------------------------
    // every pin has a board pull-up, so a released line reads high
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (pin_oe_i[i])
                level_o[i] = pin_out_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else
                level_o[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* six_bit_port_a_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module six_bit_port_a_tb;
    logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, ack_o;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [5:0] pin_in_i, pin_out_o, pin_oe_o, analog_en_o, ext_en, ext_val;
    logic [5:0] periph_en_i, periph_out_i, periph_oe_i;
    logic counter_clock_o, ref_select_o, result_justify_select_o;
    int num_errors, n_tests;
    localparam logic [9:0] A_PIN = {port_a_pkg::IDX_PINS, 2'b00};
    localparam logic [9:0] A_DIR = {port_a_pkg::IDX_DIRECTION, 2'b00};
    localparam logic [9:0] A_CFG = {port_a_pkg::IDX_ANALOG_CFG, 2'b00};
    localparam logic [9:0] A_NONE = 10'h018;
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h2};
    logic [5:0] masks [5] = '{6'h2F, 6'h27, 6'h00, 6'h00, 6'h0B};

    // ----------------------------------------
    // design, board and clock
    // ----------------------------------------
    six_bit_port_a dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .periph_en_i(periph_en_i), .periph_out_i(periph_out_i),
        .periph_oe_i(periph_oe_i), .counter_clock_o(counter_clock_o),
        .analog_en_o(analog_en_o), .ref_select_o(ref_select_o),
        .result_justify_select_o(result_justify_select_o));
    pin_board_model board_u (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pin_in_i));

    // free-running 100 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; read data lands in rd
    task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s,
            input logic [7:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h00_0000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // reset for six cycles, with or without power-on marking
    task automatic do_reset(input logic p);
        rst_i <= 1'b1;
        por_i <= p;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        {rst_i, por_i, cyc_i, stb_i, we_i} = 5'h18;
        {adr_i, sel_i, dat_i} = '0;
        {periph_en_i, periph_out_i, periph_oe_i} = '0;
        ext_en = 6'h3F;
        ext_val = 6'h3F;
        num_errors = 0;
        n_tests = 0;
        do_reset(1'b1);
        repeat (2) @(posedge clk_i);
        check(pin_oe_o, 32'h0000_0000);
        check(analog_en_o, 32'h0000_002F);
        bus(0, A_DIR, 4'h1, 8'h00);
        check(rd, 32'h0000_003F);
        bus(0, A_CFG, 4'h1, 8'h00);
        check(rd, 32'h0000_0000);
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_0010);
        bus(0, A_NONE, 4'h1, 8'h00);
        check(rd, 32'h0000_0000);
        // four named analog codes and default code 2: readback, pin mask, reference select
        for (int i = 0; i < 5; i++)
        begin
            bus(1, A_CFG, 4'h1, {4'hF, codes[i]});
            bus(0, A_CFG, 4'h1, 8'h00);
            check(rd, {24'h00_0000, 4'h8, codes[i]});
            check(analog_en_o, masks[i]);
            check(ref_select_o, codes[i] == 4'h1);
            check(result_justify_select_o, 1'b1);
        end
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_0034);
        // all digital, external levels read back
        bus(1, A_CFG, 4'h1, 8'h06);
        ext_val <= 6'h1A;
        repeat (3) @(posedge clk_i);
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_001A);
        check(counter_clock_o, 1'b1);
        bus(1, A_DIR, 4'h1, 8'hFF);
        bus(0, A_DIR, 4'h1, 8'h00);
        check(rd, 32'h0000_003F);
        bus(1, A_PIN, 4'h1, 8'h15);
        check(pin_oe_o, 32'h0000_0000);
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_001A);
        // outputs: push-pull bits and open-drain bit 4
        ext_en <= 6'h00;
        bus(1, A_DIR, 4'h1, 8'h00);
        repeat (4) @(posedge clk_i);
        check(pin_out_o, 32'h0000_0005);
        check(pin_oe_o, 32'h0000_002F);
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_0015);
        bus(1, A_PIN, 4'h1, 8'h0A);
        repeat (4) @(posedge clk_i);
        check(pin_out_o, 32'h0000_000A);
        check(pin_oe_o, 32'h0000_003F);
        bus(0, A_PIN, 4'h1, 8'h00);
        check(rd, 32'h0000_000A);
        check(counter_clock_o, 1'b0);
        // peripheral takes over bit 0
        periph_en_i <= 6'h01;
        periph_out_i <= 6'h01;
        periph_oe_i <= 6'h01;
        repeat (3) @(posedge clk_i);
        check(pin_out_o, 32'h0000_000B);
        periph_oe_i <= 6'h00;
        repeat (3) @(posedge clk_i);
        check(pin_oe_o, 32'h0000_003E);
        periph_en_i <= 6'h00;
        // write with no byte lane stores sampled pins
        bus(1, A_DIR, 4'h1, 8'h3F);
        ext_en <= 6'h3F;
        ext_val <= 6'h33;
        repeat (3) @(posedge clk_i);
        bus(1, A_PIN, 4'h0, 8'h00);
        ext_en <= 6'h00;
        bus(1, A_DIR, 4'h1, 8'h00);
        bus(1, A_NONE, 4'h1, 8'h3F);
        repeat (2) @(posedge clk_i);
        check(pin_out_o, 32'h0000_0023);
        check(pin_oe_o, 32'h0000_002F);
        // soft reset keeps latch bit 4, power-on clears it
        do_reset(1'b0);
        check(pin_oe_o, 32'h0000_0000);
        bus(1, A_DIR, 4'h1, 8'h00);
        repeat (2) @(posedge clk_i);
        check(pin_oe_o, 32'h0000_002F);
        check(pin_out_o, 32'h0000_0000);
        do_reset(1'b1);
        bus(1, A_DIR, 4'h1, 8'h00);
        repeat (2) @(posedge clk_i);
        check(pin_oe_o, 32'h0000_003F);
        summarize();
    end
endmodule
`default_nettype wire
